// ### rtl/spc_pkg.sv
package spc_pkg;
  // register addresses (8-bit register space)
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_PLL_A = 8'h04;
  localparam logic [7:0] ADDR_DIV4_CYC = 8'h52;
  localparam logic [7:0] ADDR_DIV4_PHASE = 8'h53;
  localparam logic [7:0] ADDR_FUNC_SYNC = 8'h58;
  localparam logic [7:0] ADDR_UPDATE = 8'h5A;
  // port configuration fields
  localparam int CFG_LONG_INSTR_BIT = 4;
  localparam int CFG_SOFT_RESET_BIT = 5;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_THREE_WIRE_BIT = 7;
  localparam int UPDATE_BIT = 0;
  localparam int PLL_A_WIDTH = 6;
  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h10;
  localparam logic [7:0] RST_PLL_A = 8'h00;
  localparam logic [7:0] RST_DIV4_CYC = 8'h11;
  localparam logic [7:0] RST_DIV4_PHASE = 8'h00;
  localparam logic [7:0] RST_FUNC_SYNC = 8'h00;
  // instruction framing
  localparam int INSTR_SHORT_BITS = 8;
  localparam int INSTR_LONG_BITS = 16;
  localparam int DATA_BITS = 8;

  // active configuration handed to the rest of the chip
  typedef struct packed {
    logic [PLL_A_WIDTH-1:0] pll_a;
    logic [7:0] div4_cycles;
    logic [7:0] div4_phase;
    logic [7:0] func_sync;
  } spc_cfg_t;

  // port configuration fields seen by the shifter
  typedef struct packed {
    logic three_wire;
    logic lsb_first;
    logic long_instr;
  } spc_mode_t;
endpackage

// ### rtl/spc_shifter.sv
// serial framing: instruction phase then one data byte per address
module spc_shifter
  import spc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic cs_n, // frame select, active low
  input wire logic sclk_rise, // one-cycle pulse at serial clock rise
  input wire logic sclk_fall, // one-cycle pulse at serial clock fall
  input wire logic sdio_in, // serial data in
  input wire spc_mode_t mode, // current port configuration
  input wire logic [7:0] rd_data, // read data for current address
  output logic wr_stb, // one-cycle write strobe
  output logic [7:0] wr_addr, // address of write
  output logic [7:0] wr_data, // byte to write
  output logic [7:0] rd_addr, // address being read
  output logic rd_phase, // high while shifting read data
  output logic out_bit // bit to drive out
);
  typedef enum {SH_INSTR, SH_DATA} spc_sh_t;
  spc_sh_t st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] tx_q, tx_d;
  logic stb_d, stb_q;
  logic [7:0] wd_q, wd_d;
  logic [7:0] rx_byte;
  logic [4:0] ilen;

  assign ilen = mode.long_instr ? 5'(INSTR_LONG_BITS) : 5'(INSTR_SHORT_BITS);
  // bit order applies to the data byte in both directions
  always_comb begin
    rx_byte = sh_q[7:0];
    if (mode.lsb_first) begin
      for (int i = 0; i < 8; i++) rx_byte[i] = sh_q[7-i];
    end
  end

  // framing state: address auto-increments after each written byte
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    addr_d = addr_q;
    tx_d = tx_q;
    stb_d = 1'b0;
    wd_d = wd_q;
    if (cs_n) begin
      st_d = SH_INSTR;
      cnt_d = '0;
      sh_d = '0;
    end else if (sclk_rise) begin
      sh_d = {sh_q[14:0], sdio_in};
      cnt_d = cnt_q + 5'd1;
      if (st_q == SH_INSTR && cnt_q + 5'd1 == ilen) begin
        rd_d = mode.long_instr ? sh_q[14] : sh_q[6];
        // short form keeps the read flag out of the 7-bit address
        addr_d = mode.long_instr ? {sh_q[6:0], sdio_in}
                                 : {1'b0, sh_q[5:0], sdio_in};
        st_d = SH_DATA;
        cnt_d = '0;
      end else if (st_q == SH_DATA && cnt_q == 5'(DATA_BITS - 1)) begin
        cnt_d = '0;
        if (!rd_q) begin
          stb_d = 1'b1;
          wd_d = mode.lsb_first ? {sdio_in, rx_byte[7:1]}
                                : {sh_q[6:0], sdio_in};
        end
      end
    end
    // capture at the first data rise, shift on the falls after it;
    // the fall ahead of the first data rise must not move the bit
    if (!cs_n && st_q == SH_DATA && rd_q) begin
      if (sclk_rise && cnt_q == '0) begin
        tx_d = rd_data;
      end else if (sclk_fall && cnt_q != '0) begin
        tx_d = mode.lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
    end
    if (stb_q) addr_d = addr_q + 8'd1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= SH_INSTR;
      sh_q <= '0;
      cnt_q <= '0;
      rd_q <= 1'b0;
      addr_q <= '0;
      tx_q <= '0;
      stb_q <= 1'b0;
      wd_q <= '0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      stb_q <= stb_d;
      wd_q <= wd_d;
    end
  end

  assign wr_stb = stb_q;
  assign wr_addr = addr_q;
  assign wr_data = wd_q;
  assign rd_addr = addr_q;
  assign rd_phase = (st_q == SH_DATA) && rd_q && !cs_n;
  // until the first data rise the first bit comes straight from rd_data
  assign out_bit = (cnt_q == '0) ?
                   (mode.lsb_first ? rd_data[0] : rd_data[7]) :
                   (mode.lsb_first ? tx_q[0] : tx_q[7]);
endmodule

// ### rtl/spc_regs.sv
// Summary of operation
// - A port configuration write acts at once, without the update strobe.
// - Bit 4 at 00 set (default) selects a 16-bit instruction, clear 8 bits.
// - Writing one to bit 5 at 00 restores every other register's default.
// - Bit 6 at 00 shifts data LSB first when set, MSB first by default.
// - Bit 7 at 00 releases the serial output pin, reading on the data pin.
// - The PLL A counter is six bits in 5:0 at address 04, upper bits unused.
module spc_regs
  import spc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic cs_n, // frame select, active low
  input wire logic sclk, // serial clock, sampled on mclk
  input wire logic sdio_in, // bidirectional data pin, input side
  output logic sdio_out, // bidirectional data pin, output side
  output logic sdio_oe, // bidirectional data pin drive enable
  output logic serial_output_pin, // dedicated serial output
  output logic serial_output_oe, // dedicated output drive enable
  output spc_cfg_t active_cfg // configuration in force
);
  logic sclk_q;
  logic sclk_rise, sclk_fall;
  logic [7:0] port_cfg_q, port_cfg_d;
  logic [7:0] st_pll_a_q, st_pll_a_d;
  logic [7:0] st_cyc_q, st_cyc_d;
  logic [7:0] st_ph_q, st_ph_d;
  logic [7:0] st_fs_q, st_fs_d;
  spc_cfg_t act_q, act_d;
  spc_mode_t mode;
  logic wr_stb, rd_phase, out_bit;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [7:0] rd_data;

  // serial clock edge pulses; input is treated as synchronous
  always_ff @(posedge mclk) begin
    if (rst) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;

  assign mode.long_instr = port_cfg_q[CFG_LONG_INSTR_BIT];
  assign mode.lsb_first = port_cfg_q[CFG_LSB_FIRST_BIT];
  assign mode.three_wire = port_cfg_q[CFG_THREE_WIRE_BIT];

  spc_shifter u_shift (
    .mclk(mclk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .sdio_in(sdio_in),
    .mode(mode),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_phase(rd_phase),
    .out_bit(out_bit)
  );

  // read mux shows staged copies; unused bits and addresses read zero
  always_comb begin
    case (rd_addr)
      ADDR_PORT_CFG: rd_data = {port_cfg_q[7:4], 4'h0};
      ADDR_PLL_A: rd_data = {2'b00, st_pll_a_q[PLL_A_WIDTH-1:0]};
      ADDR_DIV4_CYC: rd_data = st_cyc_q;
      ADDR_DIV4_PHASE: rd_data = st_ph_q;
      ADDR_FUNC_SYNC: rd_data = {1'b0, st_fs_q[6:0]};
      default: rd_data = 8'h00;
    endcase
  end

  // register writes, soft reset and update transfer
  always_comb begin
    port_cfg_d = port_cfg_q;
    st_pll_a_d = st_pll_a_q;
    st_cyc_d = st_cyc_q;
    st_ph_d = st_ph_q;
    st_fs_d = st_fs_q;
    act_d = act_q;
    if (wr_stb) begin
      case (wr_addr)
        // soft reset bit is not kept, it acts and clears itself
        ADDR_PORT_CFG: begin
          port_cfg_d = {wr_data[7:6], 1'b0, wr_data[4], 4'h0};
        end
        ADDR_PLL_A: st_pll_a_d = {2'b00, wr_data[PLL_A_WIDTH-1:0]};
        ADDR_DIV4_CYC: st_cyc_d = wr_data;
        ADDR_DIV4_PHASE: st_ph_d = wr_data;
        ADDR_FUNC_SYNC: st_fs_d = {1'b0, wr_data[6:0]};
        ADDR_UPDATE: begin
          if (wr_data[UPDATE_BIT]) begin
            act_d.pll_a = st_pll_a_q[PLL_A_WIDTH-1:0];
            act_d.div4_cycles = st_cyc_q;
            act_d.div4_phase = st_ph_q;
            act_d.func_sync = st_fs_q;
          end
        end
        default: ;
      endcase
      // defaults everywhere except the port configuration itself
      if (wr_addr == ADDR_PORT_CFG && wr_data[CFG_SOFT_RESET_BIT]) begin
        st_pll_a_d = RST_PLL_A;
        st_cyc_d = RST_DIV4_CYC;
        st_ph_d = RST_DIV4_PHASE;
        st_fs_d = RST_FUNC_SYNC;
        act_d.pll_a = RST_PLL_A[PLL_A_WIDTH-1:0];
        act_d.div4_cycles = RST_DIV4_CYC;
        act_d.div4_phase = RST_DIV4_PHASE;
        act_d.func_sync = RST_FUNC_SYNC;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port_cfg_q <= RST_PORT_CFG;
      st_pll_a_q <= RST_PLL_A;
      st_cyc_q <= RST_DIV4_CYC;
      st_ph_q <= RST_DIV4_PHASE;
      st_fs_q <= RST_FUNC_SYNC;
      act_q <= '{pll_a: RST_PLL_A[PLL_A_WIDTH-1:0],
                 div4_cycles: RST_DIV4_CYC,
                 div4_phase: RST_DIV4_PHASE,
                 func_sync: RST_FUNC_SYNC};
    end else begin
      port_cfg_q <= port_cfg_d;
      st_pll_a_q <= st_pll_a_d;
      st_cyc_q <= st_cyc_d;
      st_ph_q <= st_ph_d;
      st_fs_q <= st_fs_d;
      act_q <= act_d;
    end
  end

  // pin steering: three-wire returns data on the bidirectional pin
  assign sdio_out = out_bit;
  assign sdio_oe = rd_phase & mode.three_wire;
  assign serial_output_pin = out_bit;
  assign serial_output_oe = rd_phase & ~mode.three_wire;
  assign active_cfg = act_q;
endmodule

// ### verif/spc_checker.sv
module spc_checker
  import spc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst, // sync reset
  input wire logic cs_n, // frame select
  input wire logic sdio_oe, // data pin enable
  input wire logic serial_output_oe, // output pin enable
  input wire spc_cfg_t active_cfg // config in force
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  localparam spc_cfg_t DEF = {RST_PLL_A[5:0], RST_DIV4_CYC,
    RST_DIV4_PHASE, RST_FUNC_SYNC};
  // pin ownership: never two drivers, only inside a frame
  chk_oe_exclusive: assert property (!(sdio_oe && serial_output_oe))
    else $error("both pins driven");
  chk_data_oe_frame: assert property (sdio_oe |-> !cs_n)
    else $error("data pin driven outside frame");
  chk_out_oe_frame: assert property (serial_output_oe |-> !cs_n)
    else $error("output pin driven outside frame");
  // enables stand for the whole read phase
  chk_out_oe_holds: assert property ($fell(serial_output_oe) |->
    cs_n || $past(cs_n)) else $error("output pin dropped in frame");
  chk_data_oe_holds: assert property ($fell(sdio_oe) |->
    cs_n || $past(cs_n)) else $error("data pin dropped in frame");
  // frame select was already low eight clocks before any read data enable rises
  chk_instr_first: assert property ($rose(sdio_oe || serial_output_oe)
    |-> !$past(cs_n, 8)) else $error("read data before instruction");
  chk_reset_defaults: assert property ($fell(rst) |-> active_cfg == DEF
    && !sdio_oe && !serial_output_oe) else $error("bad reset state");
  // active values only move on a strobe, which needs a frame
  chk_cfg_idle: assert property (cs_n [*3] |-> $stable(active_cfg))
    else $error("active config moved while idle");
endmodule

bind spc_regs spc_checker u_chk (.mclk(mclk), .rst(rst), .cs_n(cs_n),
  .sdio_oe(sdio_oe), .serial_output_oe(serial_output_oe),
  .active_cfg(active_cfg));

// ### verif/spc_host_model.sv
module spc_host_model
  import spc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sdio_out, // device data out
  input wire logic sdio_oe, // device data enable
  input wire logic serial_output_pin, // device output pin
  input wire logic serial_output_oe, // device output pin enable
  output logic cs_n, // frame select
  output logic sclk, // serial clock
  output logic sdio_in // resolved data pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hd = 1'b0;
  logic hoe = 1'b1;
  logic long_m = 1'b1;
  logic lsb_m = 1'b0;
  logic three_m = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // released pin shows the inverse, so a stale value never passes
  assign sdio_in = sdio_oe ? sdio_out : (hoe ? hd : ~hd);
  // one bit: low half, sample read data, high half
  task automatic bit_io(input logic b, output logic s);
    @(posedge mclk);
    #1;
    sclk = 1'b0;
    hd = b;
    repeat (3) @(posedge mclk);
    #1;
    // a released output pin reads inverted, so a missing enable shows
    s = three_m ? sdio_in : (serial_output_oe ? serial_output_pin
                                              : ~serial_output_pin);
    sclk = 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // one frame: instruction then one data byte
  task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [7:0] wd, output logic [7:0] r);
    logic [15:0] ins;
    logic s;
    int n;
    ins = long_m ? {rd, 7'h00, a} : {rd, a[6:0], 8'h00};
    n = long_m ? 16 : 8;
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      bit_io(ins[15-i], s);
    end
    hoe = !rd;
    for (int i = 0; i < 8; i++) begin
      bit_io(wd[lsb_m ? i : 7-i], r[lsb_m ? i : 7-i]);
    end
    @(posedge mclk);
    #1;
    sclk = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    cs_n = 1'b1;
    hoe = 1'b1;
    // port setup is live for the very next frame
    if (!rd && a == ADDR_PORT_CFG) begin
      long_m = wd[CFG_LONG_INSTR_BIT];
      lsb_m = wd[CFG_LSB_FIRST_BIT];
      three_m = wd[CFG_THREE_WIRE_BIT];
    end
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ### verif/testbench.sv
module testbench
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, sdio_in, sdio_out, sdio_oe;
  logic serial_output_pin, serial_output_oe;
  spc_cfg_t active_cfg;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] r;
  localparam spc_cfg_t DEF = {RST_PLL_A[5:0], RST_DIV4_CYC,
    RST_DIV4_PHASE, RST_FUNC_SYNC};
  initial begin
    forever #10 mclk = ~mclk;
  end
  spc_regs i_spc_regs (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_output_pin(serial_output_pin),
    .serial_output_oe(serial_output_oe), .active_cfg(active_cfg));
  spc_host_model host (.mclk(mclk), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_output_pin(serial_output_pin),
    .serial_output_oe(serial_output_oe),
    .cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_in));
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmpcfg(input spc_cfg_t g, input spc_cfg_t e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b1, a, 8'h00, r);
  endtask
  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // defaults, then staged writes held back until the strobe
  task automatic t_stage();
    rd(ADDR_PORT_CFG);
    cmp8(r, RST_PORT_CFG);
    wr(ADDR_PLL_A, 8'hFF);
    rd(ADDR_PLL_A);
    cmp8(r, 8'h3F);
    wr(ADDR_DIV4_CYC, 8'hA5);
    cmpcfg(active_cfg, DEF);
    wr(ADDR_UPDATE, 8'h01);
    rd(ADDR_UPDATE);
    cmp8(r, 8'h00);
    cmpcfg(active_cfg, {6'h3F, 8'hA5, RST_DIV4_PHASE, RST_FUNC_SYNC});
    $display("stage test done");
  endtask
  // asymmetric byte exposes a wrong bit order
  task automatic t_lsb();
    wr(ADDR_PORT_CFG, 8'h50);
    wr(ADDR_FUNC_SYNC, 8'h01);
    rd(ADDR_FUNC_SYNC);
    cmp8(r, 8'h01);
    rd(ADDR_PORT_CFG);
    cmp8(r, 8'h50);
    $display("bit order test done");
  endtask
  // short instruction, then three-wire readback
  task automatic t_modes();
    wr(ADDR_PORT_CFG, 8'h00);
    wr(ADDR_DIV4_PHASE, 8'h07);
    rd(ADDR_DIV4_PHASE);
    cmp8(r, 8'h07);
    wr(ADDR_PORT_CFG, 8'h80);
    rd(ADDR_DIV4_PHASE);
    cmp8(r, 8'h07);
    $display("mode test done");
  endtask
  // soft reset clears staged and active but keeps port setup
  task automatic t_soft();
    wr(ADDR_PORT_CFG, 8'hA0);
    rd(ADDR_DIV4_PHASE);
    cmp8(r, RST_DIV4_PHASE);
    rd(ADDR_PORT_CFG);
    cmp8(r, 8'h80);
    cmpcfg(active_cfg, DEF);
    $display("soft reset test done");
  endtask
  initial begin
    repeat (50000) @(posedge mclk);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_stage();
    t_lsb();
    t_modes();
    t_soft();
    conclude();
  end
endmodule
